//--- design/acc_pkg.sv
// package: register map, field positions, timing and types for adc control
package acc_pkg;
    localparam logic [11:0] ACC_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] ACC_CAL_OFFSET = 12'h004;
    localparam logic [11:0] ACC_STAT_OFFSET = 12'h008;
    localparam logic [11:0] ACC_MASK_OFFSET = 12'h00C;
    localparam logic [11:0] ACC_STATE_OFFSET = 12'h010;
    localparam int ACC_ON_BIT = 15;
    localparam int ACC_SIDL_BIT = 13;
    localparam int ACC_CAL_DONE_BIT = 15;
    localparam int ACC_CAL_EN_BIT = 9;
    localparam int ACC_CAL_START_BIT = 8;
    localparam logic [15:0] ACC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ACC_CAL_RESET = 16'h0000;
    localparam logic [15:0] ACC_CTRL_WMASK = 16'hA000;
    localparam logic [15:0] ACC_CAL_WMASK = 16'h0300;
    localparam logic [1:0] ACC_IRQ_RESET = 2'h0;
    // calibration length in ns and derived cycles at 100 MHz
    localparam int ACC_CLK_MHZ = 100;
    localparam int ACC_CAL_TIME_NS = 1000;
    localparam int ACC_CAL_CYCLES = (ACC_CAL_TIME_NS * ACC_CLK_MHZ) / 1000;
    localparam int ACC_IRQ_CAL_DONE = 0;
    localparam int ACC_IRQ_ENABLE = 1;

    typedef enum logic [1:0] {
        ACC_CAL_IDLE,
        ACC_CAL_BUSY,
        ACC_CAL_DONE
    } acc_cal_state_t;

    typedef struct packed {
        logic converter_on;
        logic converter_stop_in_idle;
    } acc_ctrl_t;

    typedef struct packed {
        logic shared_core_cal_done;
        logic shared_core_cal_access_enable;
        logic shared_core_cal_start;
    } acc_cal_t;
endpackage : acc_pkg

//--- design/acc_cal_timer.sv
// calibration sequencer: counts the shared core calibration cycle
`timescale 1ns/1ps
module acc_cal_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic busy,
    output logic done_pulse
);
    logic [15:0] count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
            busy <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                count <= 16'(acc_pkg::ACC_CAL_CYCLES - 1);
            end else if (busy) begin
                if (count == 16'h0000) begin
                    busy <= 1'b0;
                    done_pulse <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end
endmodule : acc_cal_timer

//--- design/acc_ctrl.sv
// adc enable and calibration control with apb register slave
`timescale 1ns/1ps
module acc_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idle_mode,
    output logic converter_run,
    output logic cal_active,
    output logic irq
);
    acc_pkg::acc_ctrl_t ctrl;
    acc_pkg::acc_cal_t cal;
    acc_pkg::acc_cal_state_t cal_state;
    acc_pkg::acc_cal_state_t next_cal_state;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic cal_go;
    logic cal_busy;
    logic cal_done_pulse;
    logic on_rise;
    logic on_last;
    logic cal_done_flag;
    logic cal_access_en;
    logic cal_start_flag;
    logic [15:0] wdata16;
    logic [15:0] ctrl_rd;
    logic [15:0] cal_rd;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    // one driver per flag; the struct is only a view of them
    assign cal = {cal_done_flag, cal_access_en, cal_start_flag};
    assign hit = (paddr == acc_pkg::ACC_CTRL_OFFSET)
        || (paddr == acc_pkg::ACC_CAL_OFFSET)
        || (paddr == acc_pkg::ACC_STAT_OFFSET)
        || (paddr == acc_pkg::ACC_MASK_OFFSET)
        || (paddr == acc_pkg::ACC_STATE_OFFSET);
    assign pslverr = psel && penable && !hit;
    // byte lanes: only the low halfword holds bits
    assign wdata16 = {pstrb[1] ? pwdata[15:8] : 8'h00,
        pstrb[0] ? pwdata[7:0] : 8'h00};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
        end else if (wr_en && paddr == acc_pkg::ACC_CTRL_OFFSET
                && pstrb[1]) begin
            ctrl.converter_on <= wdata16[acc_pkg::ACC_ON_BIT];
            ctrl.converter_stop_in_idle <= wdata16[acc_pkg::ACC_SIDL_BIT];
        end
    end

    assign converter_run = ctrl.converter_on
        && !(ctrl.converter_stop_in_idle && idle_mode);

    assign cal_go = wr_en && paddr == acc_pkg::ACC_CAL_OFFSET && pstrb[1]
        && wdata16[acc_pkg::ACC_CAL_EN_BIT]
        && (cal.shared_core_cal_access_enable
            || wdata16[acc_pkg::ACC_CAL_EN_BIT])
        && wdata16[acc_pkg::ACC_CAL_START_BIT]
        && cal_state != acc_pkg::ACC_CAL_BUSY;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_access_en <= 1'b0;
        end else if (wr_en && paddr == acc_pkg::ACC_CAL_OFFSET
                && pstrb[1]) begin
            cal_access_en <= wdata16[acc_pkg::ACC_CAL_EN_BIT];
        end
    end

    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            acc_pkg::ACC_CAL_IDLE: begin
                if (cal_go) begin
                    next_cal_state = acc_pkg::ACC_CAL_BUSY;
                end
            end
            acc_pkg::ACC_CAL_BUSY: begin
                if (cal_done_pulse) begin
                    next_cal_state = acc_pkg::ACC_CAL_DONE;
                end
            end
            acc_pkg::ACC_CAL_DONE: begin
                if (cal_go) begin
                    next_cal_state = acc_pkg::ACC_CAL_BUSY;
                end
            end
            default: next_cal_state = acc_pkg::ACC_CAL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_state <= acc_pkg::ACC_CAL_IDLE;
        end else begin
            cal_state <= next_cal_state;
        end
    end

    // start bit self clears once the sequencer is busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_start_flag <= 1'b0;
        end else if (cal_go) begin
            cal_start_flag <= 1'b1;
        end else if (cal_busy) begin
            cal_start_flag <= 1'b0;
        end
    end

    // done low from start to completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_done_flag <= 1'b0;
        end else if (cal_done_pulse) begin
            cal_done_flag <= 1'b1;
        end else if (cal_go) begin
            cal_done_flag <= 1'b0;
        end
    end

    acc_cal_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(cal.shared_core_cal_start),
        .busy(cal_busy),
        .done_pulse(cal_done_pulse)
    );

    assign cal_active = cal_state == acc_pkg::ACC_CAL_BUSY;

    // converter switch-on event for the status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_last <= 1'b0;
        end else begin
            on_last <= ctrl.converter_on;
        end
    end
    assign on_rise = ctrl.converter_on && !on_last;

    // sticky events; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= acc_pkg::ACC_IRQ_RESET;
        end else begin
            if (wr_en && paddr == acc_pkg::ACC_STAT_OFFSET && pstrb[0]) begin
                irq_status <= irq_status & ~wdata16[1:0]
                    | {on_rise, cal_done_pulse};
            end else begin
                irq_status <= irq_status | {on_rise, cal_done_pulse};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= acc_pkg::ACC_IRQ_RESET;
        end else if (wr_en && paddr == acc_pkg::ACC_MASK_OFFSET
                && pstrb[0]) begin
            irq_mask <= wdata16[1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // reserved and unimplemented bits read zero
    // calibration done and start bits hidden without access enable; the enable bit always reads back
    always_comb begin
        ctrl_rd = 16'h0000;
        ctrl_rd[acc_pkg::ACC_ON_BIT] = ctrl.converter_on;
        ctrl_rd[acc_pkg::ACC_SIDL_BIT] = ctrl.converter_stop_in_idle;
        cal_rd = 16'h0000;
        cal_rd[acc_pkg::ACC_CAL_EN_BIT] = cal.shared_core_cal_access_enable;
        if (cal.shared_core_cal_access_enable) begin
            cal_rd[acc_pkg::ACC_CAL_DONE_BIT] = cal.shared_core_cal_done;
            cal_rd[acc_pkg::ACC_CAL_START_BIT] = cal.shared_core_cal_start;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                acc_pkg::ACC_CTRL_OFFSET: prdata <= {16'h0000, ctrl_rd};
                acc_pkg::ACC_CAL_OFFSET: prdata <= {16'h0000, cal_rd};
                acc_pkg::ACC_STAT_OFFSET: prdata <= {30'h0, irq_status};
                acc_pkg::ACC_MASK_OFFSET: prdata <= {30'h0, irq_mask};
                acc_pkg::ACC_STATE_OFFSET: prdata <= {30'h0, cal_state};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    start_clears_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cal_go |=> cal.shared_core_cal_start ##1 cal_busy
            ##1 !cal.shared_core_cal_start)
        else $error("calibration start did not self clear");

    done_low_busy_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cal_state == acc_pkg::ACC_CAL_BUSY
            |-> !cal.shared_core_cal_done)
        else $error("done flag high during calibration");

    done_sets_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(cal_busy) |=> cal.shared_core_cal_done)
        else $error("done flag not set after calibration");

    run_needs_on_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        converter_run |-> ctrl.converter_on)
        else $error("converter runs while off");

    idle_stop_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl.converter_stop_in_idle && idle_mode) |-> !converter_run)
        else $error("converter runs in idle with stop set");

    run_in_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl.converter_on && !ctrl.converter_stop_in_idle)
            |-> converter_run)
        else $error("converter halted without stop in idle");

    cal_hidden_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cal.shared_core_cal_access_enable
            |-> cal_rd[acc_pkg::ACC_CAL_DONE_BIT] == 1'b0
            && cal_rd[acc_pkg::ACC_CAL_START_BIT] == 1'b0)
        else $error("calibration bits visible while disabled");

    rd_hidden_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == acc_pkg::ACC_CAL_OFFSET
            && !$past(cal.shared_core_cal_access_enable))
            |-> prdata[acc_pkg::ACC_CAL_DONE_BIT] == 1'b0
            && prdata[acc_pkg::ACC_CAL_START_BIT] == 1'b0)
        else $error("calibration bits read while disabled");

    ctrl_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == acc_pkg::ACC_CTRL_OFFSET)
            |-> prdata[31:16] == 16'h0000
            && (prdata[15:0] & ~acc_pkg::ACC_CTRL_WMASK) == 16'h0000)
        else $error("unimplemented control bit reads nonzero");

    cal_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == acc_pkg::ACC_CAL_OFFSET)
            |-> prdata[31:16] == 16'h0000
            && (prdata[15:0] & 16'h7CFF) == 16'h0000)
        else $error("unimplemented calibration bit reads nonzero");

    // control keeps its value without lane one
    ctrl_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == acc_pkg::ACC_CTRL_OFFSET && !pstrb[1])
            |=> $stable(ctrl))
        else $error("control changed by a write without its lane");

    cal_len_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(cal_busy) |-> cal_busy[*8])
        else $error("calibration ended too early");

    // unmasked done event raises irq
    irq_level_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cal_done_pulse && irq_mask[acc_pkg::ACC_IRQ_CAL_DONE]
            && !(wr_en && paddr == acc_pkg::ACC_MASK_OFFSET)) |=> irq)
        else $error("interrupt not raised by calibration done");

    // status bit holds until cleared
    sticky_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (irq_status[acc_pkg::ACC_IRQ_CAL_DONE]
            && !(wr_en && paddr == acc_pkg::ACC_STAT_OFFSET && pstrb[0]))
            |=> irq_status[acc_pkg::ACC_IRQ_CAL_DONE])
        else $error("status bit lost without a clear");

    // switch-on event recorded
    on_event_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(ctrl.converter_on)
            |=> irq_status[acc_pkg::ACC_IRQ_ENABLE])
        else $error("switch-on event not recorded");

    cal_run_c: cover property (@(posedge pclk) disable iff (!presetn)
        cal_go ##[1:200] cal_done_pulse);
    idle_stop_c: cover property (@(posedge pclk) disable iff (!presetn)
        ctrl.converter_on && ctrl.converter_stop_in_idle && idle_mode);
    irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    cal_again_c: cover property (@(posedge pclk) disable iff (!presetn)
        cal_go && cal_state == acc_pkg::ACC_CAL_DONE);
    bus_error_c: cover property (@(posedge pclk) disable iff (!presetn)
        pslverr);
endmodule : acc_ctrl

//--- verif/acc_ctrl_test.sv
// self-checking apb testbench for the adc enable and calibration control
`timescale 1ns/1ps
module acc_ctrl_test;
    typedef struct packed {
        logic rd;
        logic [31:0] data;
        logic err;
    } acc_note_t;
    localparam logic [11:0] CTRL = acc_pkg::ACC_CTRL_OFFSET;
    localparam logic [11:0] CAL = acc_pkg::ACC_CAL_OFFSET;
    localparam logic [11:0] STAT = acc_pkg::ACC_STAT_OFFSET;
    localparam logic [11:0] MASK = acc_pkg::ACC_MASK_OFFSET;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic idle_mode = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic converter_run;
    logic cal_active;
    logic irq;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    acc_note_t notes[$];
    acc_note_t n;
    logic [31:0] r;

    acc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle_mode(idle_mode),
        .converter_run(converter_run), .cal_active(cal_active), .irq(irq));

    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic check(string name, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // one apb transfer; the expected answer is queued for the monitor
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
            logic [3:0] s, logic [31:0] e, logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        notes.push_back('{~w, e, er});
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d, 4'hF, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'hF, e, 1'b0);
    endtask : rd

    // levels are sampled mid-cycle, once the edge updates have landed
    task automatic outs(logic run, logic act, logic i);
        @(negedge pclk);
        check("converter_run", {31'h0, run}, {31'h0, converter_run});
        check("cal_active", {31'h0, act}, {31'h0, cal_active});
        check("irq", {31'h0, i}, {31'h0, irq});
    endtask : outs

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            n = notes.pop_front();
            check("pslverr", {31'h0, n.err}, {31'h0, pslverr});
            if (n.rd) check("prdata", n.data, prdata);
        end
    end

    // a hang is cut short well beyond the few hundred cycles needed
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        int k;
        r = $urandom(32'hA538);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(12'(i * 4), 32'h0);
        apb(1'b0, 12'h014, 32'h0, 4'hF, 32'h0, 1'b1);
        apb(1'b1, 12'h018, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b1);
        outs(1'b0, 1'b0, 1'b0);
        $display("test reset and unmapped done");
        for (int i = 0; i < 6; i++) begin
            // clear reserved bit 11; the other reserved bits are written at random
            r = $urandom() & 32'hFFFF_F7FF;
            wr(CTRL, r);
            rd(CTRL, r & 32'h0000_A000);
        end
        wr(CTRL, 32'h0);
        apb(1'b1, CTRL, 32'h0000_A000, 4'h1, 32'h0, 1'b0);
        rd(CTRL, 32'h0);
        $display("test control fields done");
        for (int i = 0; i < 8; i++) begin
            wr(CTRL, {16'h0, i[2], 1'b0, i[1], 13'h0});
            idle_mode <= i[0];
            outs(i[2] & ~(i[1] & i[0]), 1'b0, 1'b0);
        end
        wr(CTRL, 32'h0);
        idle_mode <= 1'b0;
        wr(MASK, 32'h2);
        outs(1'b0, 1'b0, 1'b1);
        wr(STAT, 32'h3);
        rd(STAT, 32'h0);
        outs(1'b0, 1'b0, 1'b0);
        $display("test run and irq done");
        wr(CAL, 32'h0100);
        outs(1'b0, 1'b0, 1'b0);
        rd(CAL, 32'h0);
        wr(CAL, 32'h0200);
        rd(CAL, 32'h0200);
        wr(MASK, 32'h1);
        wr(CAL, 32'h0300);
        repeat (2) @(posedge pclk);
        rd(CAL, 32'h0200);
        outs(1'b0, 1'b1, 1'b0);
        wr(CAL, 32'h0300);
        k = 0;
        while (cal_active !== 1'b0 && k < 300) begin
            @(posedge pclk);
            k++;
        end
        check("cal_length", 32'h1, {31'h0, k >= 90 && k < 300});
        repeat (4) @(posedge pclk);
        rd(CAL, 32'h8200);
        outs(1'b0, 1'b0, 1'b1);
        rd(STAT, 32'h1);
        wr(STAT, 32'h1);
        rd(acc_pkg::ACC_STATE_OFFSET, 32'h2);
        wr(CAL, 32'h0300);
        rd(CAL, 32'h0300);
        repeat (110) @(posedge pclk);
        rd(CAL, 32'h8200);
        rd(STAT, 32'h1);
        wr(STAT, 32'h1);
        outs(1'b0, 1'b0, 1'b0);
        wr(CAL, 32'h0);
        rd(CAL, 32'h0);
        $display("test calibration done");
        complete_run();
    end
endmodule : acc_ctrl_test
